//--- rtl/charger_regs_pkg.sv
// package: register map, reset values, field constants and carrier types
package charger_regs_pkg;

    // ****************************************************
    // clock and timing
    // ****************************************************
    localparam int          CLK_HZ      = 25_000_000;
    localparam int          TICK_S      = 1;
    localparam int          SEC_CYCLES  = CLK_HZ * TICK_S;
    localparam logic [7:0]  TO_S_40     = 8'd40;
    localparam logic [7:0]  TO_S_80     = 8'd80;
    localparam logic [7:0]  TO_S_160    = 8'd160;

    // ****************************************************
    // register map
    // ****************************************************
    localparam int NREG = 10;
    localparam int IDX_STATUS = 4;
    localparam int IDX_FAULT  = 5;
    localparam int IDX_ID     = 6;
    localparam logic [7:0] ADDR_CURRENT  = 8'h02;
    localparam int         SOFT_RST_BIT  = 7;
    localparam int         RESTART_BIT   = 6;
    localparam logic [1:0] STATUS_RSVD   = 2'b10;
    localparam logic [7:0] REG_ADDR [NREG] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                               8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h22};
    localparam logic [7:0] REG_RST  [NREG] = '{8'ha3, 8'h7a, 8'hc0, 8'h38, 8'h40,
                                               8'h00, 8'h00, 8'h43, 8'h10, 8'h03};
    localparam logic [7:0] REG_WMASK[NREG] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
                                               8'hc0, 8'h00, 8'hbf, 8'hcd, 8'h08};
    localparam logic [7:0] REG_WDMASK[NREG] = '{8'hff, 8'h1f, 8'hdf, 8'hf0, 8'h00,
                                                8'h00, 8'h00, 8'hbf, 8'hcd, 8'h08};

    // ****************************************************
    // field value constants
    // ****************************************************
    localparam logic [12:0] VBAT_BASE_MV = 13'd3600;
    localparam logic [6:0]  VBAT_STEP_MV = 7'd15;
    localparam logic [12:0] VSYS_BASE_MV = 13'd4200;
    localparam logic [6:0]  VSYS_STEP_MV = 7'd50;
    localparam logic [11:0] PRE_LO_MV    = 12'd2800;
    localparam logic [11:0] PRE_HI_MV    = 12'd3000;
    localparam logic [7:0]  RECH_LO_MV   = 8'd100;
    localparam logic [7:0]  RECH_HI_MV   = 8'd200;
    localparam logic [6:0]  TJ_BASE_C    = 7'd60;
    localparam logic [6:0]  TJ_STEP_C    = 7'd20;
    localparam logic [3:0]  FAST_H [4]   = '{4'd3, 4'd5, 4'd8, 4'd12};
    localparam logic [1:0]  TERM_DGL_S0  = 2'd3;
    localparam logic [1:0]  TERM_DGL_S1  = 2'd1;
    localparam logic [1:0]  PRE_TO_H0    = 2'd1;
    localparam logic [1:0]  PRE_TO_H1    = 2'd2;
    localparam logic [10:0] EXIT_SLOW_MS = 11'd2000;
    localparam logic [10:0] EXIT_FAST_MS = 11'd100;
    localparam logic [1:0]  RST_DLY_S1   = 2'd2;
    localparam logic [3:0]  BOOST_CODE   = 4'hf;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_DEV     = 4'b0001,
        ST_DEV_ACK = 4'b0010,
        ST_REG     = 4'b0011,
        ST_REG_ACK = 4'b0100,
        ST_WR      = 4'b0101,
        ST_WR_ACK  = 4'b0110,
        ST_RD      = 4'b0111,
        ST_RD_ACK  = 4'b1000
    } link_state_t;

    typedef struct packed {
        logic [1:0] charge_phase;
        logic       power_path_active;
        logic       input_power_good;
        logic       thermal_regulation_active;
    } status_t;

    typedef struct packed {
        logic       input_fault_flag;
        logic       thermal_shutdown_flag;
        logic       battery_overvolt_flag;
        logic       safety_timer_expired_flag;
        logic [1:0] thermistor_hot_cold_flags;
    } faults_t;

    typedef struct packed {
        logic [7:0] charge_voltage_cfg;
        logic [7:0] termination_timer_cfg;
        logic [7:0] main_cfg;
        logic [7:0] system_rail_cfg;
        logic [1:0] ship_entry_deglitch;
        logic [7:0] individual_charge_cfg;
        logic [7:0] extra_function_cfg;
        logic [7:0] extra_function_cfg_b;
    } cfg_t;

    typedef struct packed {
        logic [4:0]  termination_ma;
        logic [12:0] battery_target_mv;
        logic [11:0] precharge_threshold_mv;
        logic [7:0]  recharge_offset_mv;
        logic        termination_allow;
        logic [1:0]  termination_deglitch_s;
        logic        safety_timer_on;
        logic [3:0]  fast_charge_hours;
        logic [1:0]  precharge_timeout_h;
        logic        timer_doubled;
        logic        battery_switch_off;
        logic [4:0]  alert_masks;
        logic        board_overtemp_disable;
        logic        input_regulation_loop_disable;
        logic [6:0]  die_temp_limit_c;
        logic [12:0] system_rail_mv;
        logic [3:0]  ship_entry_s;
        logic        charge_current_quarter;
        logic [4:0]  precharge_ma;
        logic [10:0] ship_exit_plug_ms;
        logic [10:0] alert_ship_exit_ms;
        logic        input_limit_550;
        logic        alert_pin_ship_disable;
        logic [1:0]  system_reset_delay_s;
    } phys_t;

    function automatic logic [7:0] timeout_seconds(input logic [1:0] sel);
        case (sel)
            2'b01:   timeout_seconds = TO_S_40;
            2'b10:   timeout_seconds = TO_S_80;
            2'b11:   timeout_seconds = TO_S_160;
            default: timeout_seconds = 8'd0;
        endcase
    endfunction

endpackage

//--- rtl/host_timeout_timer.sv
// host timeout: counts whole seconds, pulses on expiry
`timescale 1ns/1ps
module host_timeout_timer
    import charger_regs_pkg::*;
#(
    parameter int TICK_CYCLES = SEC_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       run_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       restart_i,
    output logic            expire_o
);
    localparam int PW = $clog2(TICK_CYCLES + 1);

    logic [PW-1:0] pre_q;
    logic [7:0]    sec_q;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || !run_i || restart_i) begin
            pre_q    <= '0;
            sec_q    <= 8'd0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (pre_q == PW'(TICK_CYCLES - 1)) begin
                pre_q <= '0;
                // a shorter select written after the count has reached it expires at the next second tick, never wraps
                if (sec_q + 8'd1 >= timeout_seconds(sel_i)) begin
                    sec_q    <= 8'd0;
                    expire_o <= 1'b1;
                end else begin
                    sec_q <= sec_q + 8'd1;
                end
            end else begin
                pre_q <= pre_q + PW'(1);
            end
        end
    end
endmodule

//--- rtl/serial_target.sv
// two-wire serial target with auto-incrementing register address
`timescale 1ns/1ps
module serial_target
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary value
) (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [7:0] rdata_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o
);
    link_state_t st_q;
    logic        scl_q, sda_q, rw_q, nack_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q, tx_q;
    logic        rise, fall, start, stop;

    assign sda_o = 1'b0;
    assign rise  = scl_i & ~scl_q;
    assign fall  = ~scl_i & scl_q;
    assign start = scl_i & scl_q & sda_q & ~sda_i;
    assign stop  = scl_i & scl_q & ~sda_q & sda_i;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'd0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            addr_o <= 8'h00;
            wdata_o <= 8'h00;
            wr_o <= 1'b0;
            sda_oe_o <= 1'b0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            wr_o <= 1'b0;
            if (start) begin
                st_q <= ST_DEV;
                cnt_q <= 4'd0;
                sda_oe_o <= 1'b0;
            end else if (stop) begin
                st_q <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (rise) begin
                if (st_q == ST_RD_ACK) begin
                    nack_q <= sda_i;
                end else if (st_q == ST_DEV || st_q == ST_REG || st_q == ST_WR) begin
                    sh_q <= {sh_q[6:0], sda_i};
                    cnt_q <= cnt_q + 4'd1;
                end
            end else if (fall) begin
                case (st_q)
                    ST_DEV: if (cnt_q == 4'd8) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            sda_oe_o <= 1'b1;
                            rw_q <= sh_q[0];
                            st_q <= ST_DEV_ACK;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_REG: if (cnt_q == 4'd8) begin
                        addr_o <= sh_q;
                        sda_oe_o <= 1'b1;
                        st_q <= ST_REG_ACK;
                    end
                    ST_WR: if (cnt_q == 4'd8) begin
                        wdata_o <= sh_q;
                        wr_o <= 1'b1;
                        sda_oe_o <= 1'b1;
                        st_q <= ST_WR_ACK;
                    end
                    ST_REG_ACK, ST_WR_ACK: begin
                        sda_oe_o <= 1'b0;
                        cnt_q <= 4'd0;
                        st_q <= ST_WR;
                        if (st_q == ST_WR_ACK) addr_o <= addr_o + 8'd1;
                    end
                    ST_DEV_ACK, ST_RD_ACK: begin
                        if (st_q == ST_RD_ACK && nack_q) begin
                            sda_oe_o <= 1'b0;
                            st_q <= ST_IDLE;
                        end else if (st_q == ST_DEV_ACK && !rw_q) begin
                            sda_oe_o <= 1'b0;
                            cnt_q <= 4'd0;
                            st_q <= ST_REG;
                        end else begin
                            tx_q <= {rdata_i[6:0], 1'b0};
                            sda_oe_o <= ~rdata_i[7];
                            cnt_q <= 4'd1;
                            st_q <= ST_RD;
                        end
                    end
                    ST_RD: if (cnt_q == 4'd8) begin
                        sda_oe_o <= 1'b0;
                        addr_o <= addr_o + 8'd1;
                        st_q <= ST_RD_ACK;
                    end else begin
                        sda_oe_o <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'd1;
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

//--- rtl/charger_control_status_registers.sv
// charger control and status register bank behind the serial target
//
// Contract
// - termination code n gives 1+2n mA, reset 3
// - target voltage 3.600 V plus 15 mV per code
// - precharge threshold and recharge offset select bits
// - host timeout select, zero disables despite bit7
// - termination allow and termination deglitch 3s/1s
// - safety timer enable, fast hours, precharge timeout
// - timer doubles during power path mode
// - battery switch off, kept over timeout reset
// - five alert masks, one suppresses
// - board overtemp and input loop disables
// - die temperature limit 60 to 120 C
// - system rail 4.20 V plus 50 mV steps
// - status register shows timeout, phase, power flags
// - fault bits 5:0 read-only flags
// - fault bits 7:6 select ship entry deglitch
// - identity register fixed, unaffected by writes
// - charge current quarter scaling bit
// - precharge current source selects field or discharge
// - ship exit plug and alert exit times
// - input boost only when limit code 1111
// - alert pin disabled in shipping when set
// - system reset delay 0s or 2s
// - writing bit7 of current register resets fields
// - restart bit rearms timeout; expiry restores fields
// - register address increments after each data byte
`timescale 1ns/1ps
module charger_control_status_registers
    import charger_regs_pkg::*;
#(
    parameter int         TICK_CYCLES = SEC_CYCLES,
    parameter logic [6:0] DEV_ADDR    = 7'h2a,   // arbitrary value
    parameter logic [7:0] CHIP_ID     = 8'h5a    // arbitrary value
) (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire status_t    status_i,
    input  wire faults_t    faults_i,
    input  wire logic [3:0] input_limit_code_i,
    input  wire logic [3:0] discharge_precharge_code_i,
    input  wire logic       discharge_mode_i,
    input  wire logic       power_path_mode_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output cfg_t            cfg_o,
    output phys_t           phys_o,
    output logic            soft_reset_o,
    output logic            host_timeout_reset_o,
    output logic            host_timeout_fault_o
);

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [7:0] merge(input logic [7:0] q,
                                         input logic [7:0] n,
                                         input logic [7:0] m);
        merge = (q & ~m) | (n & m);
    endfunction

    function automatic logic [4:0] odd_ma(input logic [3:0] n);
        odd_ma = {n, 1'b1};
    endfunction

    function automatic logic [12:0] step_mv(input logic [12:0] base,
                                            input logic [6:0]  step,
                                            input logic [5:0]  n);
        step_mv = base + 13'(step) * 13'(n);
    endfunction

    function automatic logic [10:0] exit_ms(input logic fast);
        exit_ms = fast ? EXIT_FAST_MS : EXIT_SLOW_MS;
    endfunction

    // ****************************************************
    // serial link
    // ****************************************************
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic       bus_wr;
    logic [7:0] rdata;

    serial_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_link (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .rdata_i    (rdata),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe_o),
        .addr_o     (bus_addr),
        .wdata_o    (bus_wdata),
        .wr_o       (bus_wr)
    );

    // ****************************************************
    // reset requests and host timeout
    // ****************************************************
    logic [7:0] regs_q [NREG];
    logic       cur_wr;
    logic       soft_rst;
    logic       restart;
    logic       tmo_run;
    logic       tmo_expire;
    logic       tmo_fault_q;

    assign cur_wr   = bus_wr && (bus_addr == ADDR_CURRENT);
    assign soft_rst = cur_wr && bus_wdata[SOFT_RST_BIT];
    assign restart  = cur_wr && bus_wdata[RESTART_BIT];
    assign tmo_run  = (regs_q[1][6:5] != 2'b00) &&
                      (!discharge_mode_i || regs_q[1][7]);

    host_timeout_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timeout (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .run_i      (tmo_run),
        .sel_i      (regs_q[1][6:5]),
        .restart_i  (restart || soft_rst),
        .expire_o   (tmo_expire)
    );

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            soft_reset_o         <= 1'b0;
            host_timeout_reset_o <= 1'b0;
        end else begin
            soft_reset_o         <= soft_rst;
            host_timeout_reset_o <= tmo_expire;
        end
    end

    // set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            tmo_fault_q <= 1'b0;
        end else if (tmo_expire) begin
            tmo_fault_q <= 1'b1;
        end else if (restart || soft_rst) begin
            tmo_fault_q <= 1'b0;
        end
    end

    assign host_timeout_fault_o = tmo_fault_q;

    // ****************************************************
    // register storage
    // ****************************************************
    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < NREG; i++) begin
            if (!rstn_i) begin
                regs_q[i] <= REG_RST[i];
            end else if (soft_rst) begin
                regs_q[i] <= REG_RST[i];
            end else if (tmo_expire) begin
                // timeout keeps battery switch, rail target, ship entry deglitch and timeout setup
                regs_q[i] <= merge(regs_q[i], REG_RST[i], REG_WDMASK[i]);
            end else if (bus_wr && bus_addr == REG_ADDR[i]) begin
                regs_q[i] <= merge(regs_q[i], bus_wdata, REG_WMASK[i]);
            end
        end
    end

    // ****************************************************
    // read mux
    // ****************************************************
    always_comb begin
        rdata = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (bus_addr == REG_ADDR[i]) begin
                rdata = regs_q[i];
            end
        end
        if (bus_addr == REG_ADDR[IDX_STATUS]) begin
            rdata = {tmo_fault_q, STATUS_RSVD, status_i};
        end
        if (bus_addr == REG_ADDR[IDX_FAULT]) begin
            rdata = {regs_q[IDX_FAULT][7:6], faults_i};
        end
        if (bus_addr == REG_ADDR[IDX_ID]) begin
            rdata = CHIP_ID;
        end
    end

    // ****************************************************
    // raw configuration out
    // ****************************************************
    assign cfg_o.charge_voltage_cfg    = regs_q[0];
    assign cfg_o.termination_timer_cfg = regs_q[1];
    assign cfg_o.main_cfg              = regs_q[2];
    assign cfg_o.system_rail_cfg       = regs_q[3];
    assign cfg_o.ship_entry_deglitch   = regs_q[IDX_FAULT][7:6];
    assign cfg_o.individual_charge_cfg = regs_q[7];
    assign cfg_o.extra_function_cfg    = regs_q[8];
    assign cfg_o.extra_function_cfg_b  = regs_q[9];

    // ****************************************************
    // decoded settings
    // ****************************************************
    phys_t phys_d;

    always_comb begin
        phys_d = '0;
        phys_d.termination_ma         = odd_ma(regs_q[7][4:1]);
        phys_d.battery_target_mv      = step_mv(VBAT_BASE_MV, VBAT_STEP_MV,
                                                regs_q[0][7:2]);
        phys_d.precharge_threshold_mv = regs_q[0][1] ? PRE_HI_MV
                                                     : PRE_LO_MV;
        phys_d.recharge_offset_mv     = regs_q[0][0] ? RECH_HI_MV
                                                     : RECH_LO_MV;
        phys_d.termination_allow      = regs_q[1][4];
        phys_d.termination_deglitch_s = regs_q[8][6] ? TERM_DGL_S1
                                                     : TERM_DGL_S0;
        phys_d.safety_timer_on        = regs_q[1][3];
        phys_d.fast_charge_hours      = FAST_H[regs_q[1][2:1]];
        phys_d.precharge_timeout_h    = regs_q[8][3] ? PRE_TO_H1
                                                     : PRE_TO_H0;
        phys_d.timer_doubled          = regs_q[2][6] & power_path_mode_i;
        phys_d.battery_switch_off     = regs_q[2][5];
        phys_d.alert_masks            = regs_q[2][4:0];
        phys_d.board_overtemp_disable = regs_q[3][7];
        phys_d.input_regulation_loop_disable = regs_q[3][6];
        phys_d.die_temp_limit_c       = TJ_BASE_C + 7'(TJ_STEP_C * regs_q[3][5:4]);
        phys_d.system_rail_mv         = step_mv(VSYS_BASE_MV, VSYS_STEP_MV,
                                                {2'b00, regs_q[3][3:0]});
        phys_d.ship_entry_s           = 4'(4'd1 << regs_q[IDX_FAULT][7:6]);
        phys_d.charge_current_quarter = regs_q[7][7];
        phys_d.precharge_ma           = regs_q[7][5] ? odd_ma(regs_q[7][4:1])
                                        : odd_ma(discharge_precharge_code_i);
        phys_d.ship_exit_plug_ms      = exit_ms(regs_q[7][0]);
        phys_d.alert_ship_exit_ms     = exit_ms(regs_q[9][3]);
        phys_d.input_limit_550        = regs_q[8][7] &&
                                        (input_limit_code_i == BOOST_CODE);
        phys_d.alert_pin_ship_disable = regs_q[8][2];
        phys_d.system_reset_delay_s   = regs_q[8][0] ? RST_DLY_S1 : 2'd0;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            phys_o <= '0;
        end else begin
            phys_o <= phys_d;
        end
    end

endmodule

//--- verif/regs_sva.sv
// checker: decode and reset behaviour of the register bank
`timescale 1ns/1ps
module regs_sva
    import charger_regs_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic [3:0] input_limit_code_i,
    input wire cfg_t       cfg_o,
    input wire phys_t      phys_o,
    input wire logic       soft_reset_o,
    input wire logic       host_timeout_reset_o,
    input wire logic       host_timeout_fault_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_vbat_decode: assert property ($past(rstn_i) |-> phys_o.battery_target_mv ==
        13'h0e10 + 13'h000f * $past(cfg_o.charge_voltage_cfg[7:2])) else $error("vbat");
    a_rail_decode: assert property ($past(rstn_i) |-> phys_o.system_rail_mv ==
        13'h1068 + 13'h0032 * $past(cfg_o.system_rail_cfg[3:0])) else $error("rail");
    a_ship_decode: assert property ($past(rstn_i) |-> phys_o.ship_entry_s ==
        4'h1 << $past(cfg_o.ship_entry_deglitch)) else $error("ship");
    a_boost_gate: assert property (phys_o.input_limit_550 ==
        ($past(cfg_o.extra_function_cfg[7]) && $past(input_limit_code_i) == 4'hf)) else $error("boost");
    a_soft_restore: assert property (soft_reset_o |->
        ##[1:2] cfg_o.main_cfg == 8'hc0) else $error("soft");
    a_wd_restore: assert property (host_timeout_reset_o |->
        ##[1:2] cfg_o.charge_voltage_cfg == 8'ha3) else $error("wd");
    a_wd_keeps: assert property (host_timeout_reset_o |=>
        $stable({cfg_o.main_cfg[5], cfg_o.system_rail_cfg[3:0]}) [*2]) else $error("keep");
    a_wd_flag: assert property (host_timeout_reset_o |->
        ##[0:1] host_timeout_fault_o) else $error("flag");
endmodule

//--- verif/bus_host.sv
// serial bus host model: drives the clock, pulls data low
`timescale 1ns/1ps
module bus_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      pull_o
);
    int hp = 3;
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    // start when s is 1, stop when s is 0
    task automatic cond(input logic s);
        pull_o <= !s;
        repeat (hp) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (hp) @(posedge clk_i);
        pull_o <= s;
        repeat (hp) @(posedge clk_i);
        scl_o <= !s;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic bit_io(input logic b, output logic r);
        pull_o <= !b;
        repeat (hp) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (hp) @(posedge clk_i);
        r = sda_i;
        scl_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ma, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ma, a);
        ack = !a;
    endtask
endmodule

//--- verif/tb_charger_control_status_registers.sv
// testbench: register bank reached through the bus host model
`timescale 1ns/1ps
module tb_charger_control_status_registers;
    logic       core_clk_i = 1'b0;
    logic       rstn_i     = 1'b0;
    logic       dmode      = 1'b0;
    import charger_regs_pkg::*;
    logic       scl, pull, oe, flt, ack, so, srst, trst;
    logic       ppm  = 1'b0;
    logic [3:0] ilim = 4'hf;
    logic [3:0] dpc  = 4'h5;
    status_t    st   = 5'h16;
    faults_t    fl   = 6'h29;
    cfg_t       cfg;
    phys_t      phys;
    wire        sda = !pull && (oe ? so : 1'b1);
    logic [7:0] rx;
    int         errors = 0;
    int         total_checks = 0;
    charger_control_status_registers #(.TICK_CYCLES(25), .DEV_ADDR(7'h3a), .CHIP_ID(8'h3c)) // arbitrary ids
    u_charger_control_status_registers (.core_clk_i, .rstn_i, .scl_i(scl), .sda_i(sda),
        .status_i(st), .faults_i(fl), .input_limit_code_i(ilim), .discharge_precharge_code_i(dpc),
        .discharge_mode_i(dmode), .power_path_mode_i(ppm), .sda_o(so), .sda_oe_o(oe), .cfg_o(cfg),
        .phys_o(phys), .soft_reset_o(srst), .host_timeout_reset_o(trst), .host_timeout_fault_o(flt));
    bus_host u_bus_host (.clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
    initial forever #20 core_clk_i = ~core_clk_i;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic head(input logic [7:0] a);
        u_bus_host.cond(1'b1);
        u_bus_host.xfer(8'h74, 1'b1, rx, ack);
        u_bus_host.xfer(a, 1'b1, rx, ack);
        check({7'h0, ack}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
        head(a);
        foreach (d[i]) u_bus_host.xfer(d[i], 1'b1, rx, ack);
        u_bus_host.cond(1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
        head(a);
        u_bus_host.cond(1'b1);
        u_bus_host.xfer(8'h75, 1'b1, rx, ack);
        foreach (e[i]) begin
            u_bus_host.xfer(8'hff, i == e.size() - 1, rx, ack);
            check(rx, e[i]);
        end
        u_bus_host.cond(1'b0);
    endtask
    initial begin
        repeat (12) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        rd(8'h04, '{8'ha3, 8'h7a, 8'hc0, 8'h38, 8'h56, 8'h29, 8'h3c, 8'h43, 8'h10});
        $display("reset values done");
        wr(8'h04, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
        rd(8'h04, '{8'hff, 8'hff, 8'hff, 8'hff, 8'h56, 8'he9, 8'h3c, 8'hff, 8'hdd});
        $display("write masks done");
        u_bus_host.hp = 6;
        wr(8'h05, '{8'h20});
        for (int i = 0; i < 4000 && flt !== 1'b1; i++) @(posedge core_clk_i);
        check({7'h0, flt}, 8'h01);
        if (flt !== 1'b1) wrap_up();
        rd(8'h04, '{8'ha3, 8'h3a, 8'he0, 8'h3f, 8'hd6});
        $display("host timeout done");
        wr(8'h02, '{8'h80});
        rd(8'h04, '{8'ha3, 8'h7a, 8'hc0, 8'h38, 8'h56, 8'h29});
        ppm <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        check({7'h0, phys.timer_doubled}, 8'h01);
        check({1'b0, phys.die_temp_limit_c}, 8'h78);
        check({3'h0, phys.precharge_ma}, 8'h0b);
        $display("soft reset done");
        dmode <= 1'b1;
        wr(8'h05, '{8'h80});
        repeat (2000) @(posedge core_clk_i);
        check({7'h0, flt}, 8'h00);
        $display("timer disable done");
        wrap_up();
    end
endmodule
bind charger_control_status_registers regs_sva u_regs_sva (.core_clk_i, .rstn_i, .input_limit_code_i,
    .cfg_o, .phys_o, .soft_reset_o, .host_timeout_reset_o, .host_timeout_fault_o);
